/* File: common/baud_pkg.sv */
// constants for the serial channel noise filter and baud rate generator
package baud_pkg;
  // register indexes; the byte address is four times the index
  localparam logic [31:0] CTL_IDX  = 32'hfffffa00;
  localparam logic [31:0] SEL_IDX  = 32'h0ffffa01;
  localparam logic [31:0] DIV_IDX  = 32'hfffffa02;
  localparam logic [31:0] STAT_IDX = 32'hfffffa03;
  // reset values
  localparam logic [3:0]  SEL_RESET = 4'h0;
  localparam logic [7:0]  DIV_RESET = 8'hff;
  localparam logic [2:0]  CTL_RESET = 3'h0;
  // control register field positions on the data bus
  localparam int CTL_POWER_BIT = 7;
  localparam int CTL_TXE_BIT   = 6;
  localparam int CTL_RXE_BIT   = 5;
  localparam int CTL_ARM_BIT   = 0;
  // status register field positions
  localparam int STAT_ERR_BIT   = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_LEVEL_BIT = 2;
  localparam int STAT_BREAK_BIT = 3;
  // base clock selection codes
  localparam logic [3:0]  SEL_MAX_DIV = 4'ha;
  localparam logic [3:0]  SEL_EXT     = 4'hb;
  localparam int          PRESC_W     = 10;
  // break shorter than or equal to 10.5 bit times, in half-bit ticks
  localparam logic [7:0]  SBF_SHORT_TICKS = 8'h15;
  // extra base clock cycles at a back-to-back start bit
  localparam logic [1:0]  B2B_HOLD = 2'h2;
  localparam logic [7:0]  COUNT_START = 8'h01;
endpackage

/* File: rtl/baud_divider.sv */
// one 8-bit programmable divider: serial tick and bit-rate tick
`timescale 1ns/1ns
`default_nettype none
module baud_divider
  import baud_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // control
  input  wire logic         base_en,
  input  wire logic         run,
  input  wire logic         restart,
  input  wire logic [1:0]   restart_hold,
  input  wire logic         first_half,
  input  wire logic [W-1:0] k,
  // ticks
  output logic              tick,
  output logic              bit_tick
);
  logic [W-1:0] count_reg;
  logic [1:0]   hold_reg;
  logic         half_reg;

  // count base clocks 1..k, reload at k; every second tick is a bit tick
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      count_reg <= W'(COUNT_START);
      hold_reg  <= 2'h0;
      half_reg  <= 1'b0;
      tick      <= 1'b0;
      bit_tick  <= 1'b0;
    end else begin
      tick     <= 1'b0;
      bit_tick <= 1'b0;
      if (restart) begin
        count_reg <= W'(COUNT_START);
        hold_reg  <= restart_hold;
        half_reg  <= first_half;
      end else if (base_en) begin
        if (hold_reg != 2'h0) begin
          hold_reg <= hold_reg - 2'h1;
        end else if (count_reg >= k) begin
          count_reg <= W'(COUNT_START);
          tick      <= 1'b1;
          half_reg  <= ~half_reg;
          bit_tick  <= half_reg;
        end else begin
          count_reg <= count_reg + W'(1);
        end
      end
    end
  end
endmodule // baud_divider
`default_nettype wire

/* File: rtl/uart_rx_filter_baud_generator.sv */
// serial channel receive noise filter and baud rate generator
// What this block does
// - sample receive pin each base clock through registers
// - filter output follows two agreeing samples only
// - pulses of one base clock are dropped
// - filtered data lags pin by two main clocks plus three base clocks
// - separate 8-bit transmit and receive counters
// - base clock reaches counters only when powered
// - select codes 0-10 divide by 2^m, 11 external on channel 0 only (no clock on other channels)
// - serial clock is base clock over k
// - bit clock is serial clock halved
// - base clock select resets zero, upper bits zero
// - divisor register resets to 255
// - both clock registers read and write bytewise
// - break ending within 10.5 bits is error
// - receive counter restarts on start bit
// - back-to-back start gets two extra base clocks
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module uart_rx_filter_baud_generator #(
  parameter int CHANNEL = 0
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [31:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // pins
  input  wire logic        serial_rx_pin,
  input  wire logic        ext_baud_clock_pin,
  // transmitter and receiver hooks
  input  wire logic        tx_start,
  input  wire logic        tx_back_to_back,
  input  wire logic        rx_hunt,
  // timing outputs
  output logic             rx_data,
  output logic             tx_baud_tick,
  output logic             rx_baud_tick,
  output logic             rx_serial_tick
);
  import baud_pkg::*;

  logic [3:0]         base_clock_select_reg;
  logic [7:0]         baud_divisor_reg;
  logic [2:0]         channel_control_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic               rx_s1, rx_s2, ext_s1, ext_s2, ext_s3;
  logic               filt_a_reg, filt_b_reg, rx_prev_reg;
  logic               sbf_armed_reg, in_break_reg;
  logic               sbf_err_reg, sbf_done_reg;
  logic [7:0]         low_ticks_reg;
  logic               base_en, channel_power_on, tx_enable_bit;
  logic               rx_enable_bit, rx_fall, rx_rise, bus_do, wr_do;
  logic               tx_serial_tick;

  assign channel_power_on = channel_control_reg[2];
  assign tx_enable_bit    = channel_control_reg[1];
  assign rx_enable_bit    = channel_control_reg[0];

  // strobe once per 2^m main clocks, or on an external clock edge when CHANNEL is 0
  function automatic logic base_strobe(input logic [3:0] code,
                                       input logic [PRESC_W-1:0] p,
                                       input logic ext_edge);
    logic [PRESC_W-1:0] mask;
    mask = PRESC_W'((11'h1 << code) - 11'h1);
    if (code <= SEL_MAX_DIV) begin
      base_strobe = ((p & mask) == mask);
    end else if (code == SEL_EXT) begin
      base_strobe = ext_edge && (CHANNEL == 0);
    end else begin
      base_strobe = 1'b0; // prohibited codes give no clock
    end
  endfunction

  // free-running binary prescaler
  always_ff @(posedge mclk) begin
    if (rst) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + PRESC_W'(1);
    end
  end

  // pins come from outside the clock domain: two flops first
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_s1  <= 1'b1;
      rx_s2  <= 1'b1;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      rx_s1  <= serial_rx_pin;
      rx_s2  <= rx_s1;
      ext_s1 <= ext_baud_clock_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // base clock is gated by channel power
  assign base_en = channel_power_on &&
                   base_strobe(base_clock_select_reg, presc_reg,
                               ext_s2 && !ext_s3);

  // noise filter: two sample stages and a match detector
  always_ff @(posedge mclk) begin
    if (rst) begin
      filt_a_reg <= 1'b1;
      filt_b_reg <= 1'b1;
      rx_data    <= 1'b1;
    end else if (base_en) begin
      filt_a_reg <= rx_s2;
      filt_b_reg <= filt_a_reg;
      if (filt_a_reg == filt_b_reg) begin
        rx_data <= filt_b_reg;
      end
    end
  end

  // edge detector on the filtered line, not on the raw pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_data;
    end
  end
  assign rx_fall = rx_prev_reg && !rx_data;
  assign rx_rise = !rx_prev_reg && rx_data;

  // transmit counter: first bit tick lands one bit after the start
  baud_divider #(.W(8)) u_tx_div (
    .mclk         (mclk),
    .rst          (rst),
    .base_en      (base_en),
    .run          (tx_enable_bit),
    .restart      (tx_start),
    .restart_hold (tx_back_to_back ? B2B_HOLD : 2'h0),
    .first_half   (1'b0),
    .k            (baud_divisor_reg),
    .tick         (tx_serial_tick),
    .bit_tick     (tx_baud_tick)
  );

  // receive counter: first bit tick lands mid start bit
  baud_divider #(.W(8)) u_rx_div (
    .mclk         (mclk),
    .rst          (rst),
    .base_en      (base_en),
    .run          (rx_enable_bit),
    .restart      (rx_fall && (rx_hunt || sbf_armed_reg)),
    .restart_hold (2'h0),
    .first_half   (1'b1),
    .k            (baud_divisor_reg),
    .tick         (rx_serial_tick),
    .bit_tick     (rx_baud_tick)
  );

  // break width measured in half-bit ticks while armed
  always_ff @(posedge mclk) begin
    if (rst) begin
      in_break_reg  <= 1'b0;
      low_ticks_reg <= '0;
    end else if (!sbf_armed_reg || !rx_enable_bit) begin
      in_break_reg  <= 1'b0;
      low_ticks_reg <= '0;
    end else if (rx_fall) begin
      in_break_reg  <= 1'b1;
      low_ticks_reg <= '0;
    end else if (rx_rise) begin
      in_break_reg  <= 1'b0;
    end else if (in_break_reg && rx_serial_tick &&
                 low_ticks_reg != 8'hff) begin
      low_ticks_reg <= low_ticks_reg + 8'h1; // saturate, never wrap
    end
  end

  // break outcome flags; a set in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      sbf_err_reg  <= 1'b0;
      sbf_done_reg <= 1'b0;
    end else begin
      if (in_break_reg && rx_rise && low_ticks_reg <= SBF_SHORT_TICKS) begin
        sbf_err_reg <= 1'b1;
      end else if (wr_do && address == STAT_IDX &&
                   writedata[STAT_ERR_BIT]) begin
        sbf_err_reg <= 1'b0;
      end
      if (in_break_reg && rx_rise && low_ticks_reg > SBF_SHORT_TICKS) begin
        sbf_done_reg <= 1'b1;
      end else if (wr_do && address == STAT_IDX &&
                   writedata[STAT_DONE_BIT]) begin
        sbf_done_reg <= 1'b0;
      end
    end
  end

  // break reception arm: set by software, cleared by a good break
  always_ff @(posedge mclk) begin
    if (rst) begin
      sbf_armed_reg <= 1'b0;
    end else if (in_break_reg && rx_rise &&
                 low_ticks_reg > SBF_SHORT_TICKS) begin
      sbf_armed_reg <= 1'b0; // a short break leaves it armed
    end else if (wr_do && address == CTL_IDX &&
                 writedata[CTL_ARM_BIT]) begin
      sbf_armed_reg <= 1'b1;
    end
  end

  // bus handshake: one wait cycle, then the access completes
  assign bus_do = (read || write) && !waitrequest;
  assign wr_do  = write && !waitrequest && byteenable[0];
  always_ff @(posedge mclk) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest) || bus_do;
    end
  end

  // register writes; only the low byte lane carries data
  always_ff @(posedge mclk) begin
    if (rst) begin
      base_clock_select_reg <= SEL_RESET;
      baud_divisor_reg      <= DIV_RESET;
      channel_control_reg   <= CTL_RESET;
    end else if (wr_do) begin
      if (address == SEL_IDX) begin
        base_clock_select_reg <= writedata[3:0];
      end
      if (address == DIV_IDX) begin
        baud_divisor_reg <= writedata[7:0];
      end
      if (address == CTL_IDX) begin
        channel_control_reg <= {writedata[CTL_POWER_BIT],
                                writedata[CTL_TXE_BIT],
                                writedata[CTL_RXE_BIT]};
      end
    end
  end

  // read data captured in the wait cycle; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      readdata <= '0;
    end else if (read && waitrequest) begin
      unique case (address)
        SEL_IDX:  readdata <= {28'h0, base_clock_select_reg};
        DIV_IDX:  readdata <= {24'h0, baud_divisor_reg};
        CTL_IDX:  readdata <= {24'h0, channel_control_reg, 4'h0,
                               sbf_armed_reg};
        STAT_IDX: readdata <= {28'h0, in_break_reg, rx_data,
                               sbf_done_reg, sbf_err_reg};
        default:  readdata <= '0;
      endcase
    end
  end

  // checker helpers: base clocks and serial ticks between ticks
  logic [8:0] gap_reg;
  logic       gap_ok_reg, odd_tick_reg;
  always_ff @(posedge mclk) begin
    if (rst || !tx_enable_bit || tx_start || wr_do) begin
      gap_reg      <= '0;
      gap_ok_reg   <= 1'b0;
      odd_tick_reg <= 1'b0;
    end else if (tx_serial_tick) begin
      gap_reg      <= {8'h0, base_en};
      gap_ok_reg   <= 1'b1;
      odd_tick_reg <= !tx_baud_tick;
    end else begin
      gap_reg <= gap_reg + {8'h0, base_en};
    end
  end

  sequence s_steady_full(logic v);
    (channel_power_on && base_clock_select_reg == 4'h0 && rx_s2 == v)[*3];
  endsequence

  property p_filter_cause;
    @(posedge mclk) disable iff (rst)
      $changed(rx_data) |-> $past(base_en && filt_a_reg == filt_b_reg);
  endproperty
  a_filter_cause: assert property (p_filter_cause)
    else $error("filtered data changed without two matching samples");

  property p_noise_drop;
    @(posedge mclk) disable iff (rst)
      (channel_power_on && base_clock_select_reg == 4'h0 && rx_data
       && filt_a_reg && filt_b_reg && !rx_s2) ##1 rx_s2 |=> ##1 rx_data;
  endproperty
  a_noise_drop: assert property (p_noise_drop)
    else $error("one-clock low pulse reached filtered data");

  property p_lag_low;
    @(posedge mclk) disable iff (rst)
      s_steady_full(1'b0) |=> !rx_data;
  endproperty
  a_lag_low: assert property (p_lag_low)
    else $error("filtered data not low three base clocks after pin");

  property p_power_gate;
    @(posedge mclk) disable iff (rst)
      (!channel_power_on)[*2] |-> !tx_serial_tick && !rx_serial_tick;
  endproperty
  a_power_gate: assert property (p_power_gate)
    else $error("serial tick while channel power is off");

  property p_div_gap;
    @(posedge mclk) disable iff (rst)
      (tx_serial_tick && gap_ok_reg) |-> gap_reg == {1'b0, baud_divisor_reg};
  endproperty
  a_div_gap: assert property (p_div_gap)
    else $error("serial tick spacing differs from divisor");

  property p_bit_half;
    @(posedge mclk) disable iff (rst)
      (tx_serial_tick && gap_ok_reg) |-> tx_baud_tick == odd_tick_reg;
  endproperty
  a_bit_half: assert property (p_bit_half)
    else $error("bit tick not on every second serial tick");

  property p_sel_reset;
    @(posedge mclk) rst |=> base_clock_select_reg == 4'h0 && waitrequest;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("base clock select not zero after reset");

  property p_div_reset;
    @(posedge mclk) rst |=> baud_divisor_reg == 8'hff;
  endproperty
  a_div_reset: assert property (p_div_reset)
    else $error("divisor not 255 after reset");

  property p_short_break;
    @(posedge mclk) disable iff (rst)
      (in_break_reg && rx_rise && low_ticks_reg <= 8'h15)
        |=> sbf_err_reg && sbf_armed_reg;
  endproperty
  a_short_break: assert property (p_short_break)
    else $error("short break not flagged as error");

  property p_rx_restart;
    @(posedge mclk) disable iff (rst)
      (rx_enable_bit && rx_fall && rx_hunt) |=> !rx_serial_tick;
  endproperty
  a_rx_restart: assert property (p_rx_restart)
    else $error("receive counter not restarted on start bit");
endmodule // uart_rx_filter_baud_generator
`default_nettype wire

/* File: sim/remote_node.sv */
// remote serial node model: receive line and external base clock
`timescale 1ns/1ns
`default_nettype none
module remote_node #(
  parameter int EXT_HALF = 3
) (
  // clock
  input  wire logic mclk,
  // line side
  output logic      line,
  output logic      ext_clk
);
  int cnt = 0;
  // line idles high, so an undriven start never looks like a start bit
  initial begin
    line = 1'b1;
    ext_clk = 1'b0;
  end
  // external base clock runs free, slower than the main clock
  always @(posedge mclk) begin
    cnt <= (cnt == EXT_HALF - 1) ? 0 : cnt + 1;
    if (cnt == EXT_HALF - 1) begin
      ext_clk <= ~ext_clk;
    end
  end
  // drive a level just after an edge
  task automatic set_line(input logic v);
    @(posedge mclk);
    line <= v;
  endtask
  // low pulse of w main clocks, then back to idle
  task automatic pulse(input int w);
    set_line(1'b0);
    repeat (w) @(posedge mclk);
    line <= 1'b1;
  endtask
endmodule // remote_node
`default_nettype wire

/* File: sim/uart_rx_filter_baud_generator_bench.sv */
// self-checking bench for the receive filter and baud generator
`timescale 1ns/1ns
`default_nettype none
module uart_rx_filter_baud_generator_bench;
  import baud_pkg::*;
  localparam int EH = 3;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] address = '0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = '0;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        rx_pin;
  logic        ext_pin;
  logic        tx_start = 1'b0;
  logic        tx_b2b = 1'b0;
  logic        rx_hunt = 1'b0;
  logic        rx_data;
  logic        tx_baud_tick;
  logic        rx_baud_tick;
  logic        rx_serial_tick;
  logic        lo;
  logic [7:0]  mreg [4];
  logic [31:0] q;
  int          num_errors = 0;
  int          n_checks = 0;
  int          c0, c1, k, m, per;

  uart_rx_filter_baud_generator #(.CHANNEL(0)) u_dut (
    .mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .serial_rx_pin(rx_pin), .ext_baud_clock_pin(ext_pin),
    .tx_start(tx_start), .tx_back_to_back(tx_b2b), .rx_hunt(rx_hunt),
    .rx_data(rx_data), .tx_baud_tick(tx_baud_tick),
    .rx_baud_tick(rx_baud_tick), .rx_serial_tick(rx_serial_tick));
  remote_node #(.EXT_HALF(EH)) u_node (
    .mclk(mclk), .line(rx_pin), .ext_clk(ext_pin));

  // 10 MHz main clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  function automatic logic [31:0] idx(input int i);
    case (i)
      0: return CTL_IDX;
      1: return SEL_IDX;
      2: return DIV_IDX;
      3: return STAT_IDX;
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic pick(input int w);
    return (w == 0) ? rx_serial_tick : (w == 1) ? tx_baud_tick : rx_baud_tick;
  endfunction

  // compare helpers, one per kind of result
  task automatic chk_reg(input string s, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_cyc(input string s, input int e, g);
    n_checks++;
    if (g != e) begin
      num_errors++;
      $display("[ERR] %s expected %0d seen %0d", s, e, g);
    end
  endtask

  // one avalon access; the request stands until waitrequest is seen low
  // values read right after a rising edge are those sampled at that edge
  task automatic bus(input logic we, input int i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    read <= !we;
    write <= we;
    address <= idx(i);
    writedata <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) num_errors++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // write and track the register model; only low byte lanes act
  task automatic wr(input int i, input logic [7:0] d);
    bus(1'b1, i, d);
    if (byteenable[0] === 1'b1 && i == 1) mreg[1] = {4'h0, d[3:0]};
    if (byteenable[0] === 1'b1 && i == 2) mreg[2] = d;
  endtask
  task automatic rd(input int i, input string s);
    bus(1'b0, i, 8'h0);
    chk_reg(s, {24'h0, mreg[i]}, q);
  endtask
  // reprogram with the channel powered down first
  task automatic cfg(input int kk, mm);
    wr(0, 8'h00);
    wr(1, mm[7:0]);
    wr(2, kk[7:0]);
    wr(0, 8'he0);
  endtask
  // cycles between two pulses of a tick output
  task automatic gap(input int w, output int c);
    int t;
    t = 0;
    do begin @(negedge mclk); t++; end while (pick(w) !== 1'b1 && t < 5000);
    c = 0;
    do begin @(negedge mclk); c++; end while (pick(w) !== 1'b1 && c < 5000);
  endtask
  // edges from a pin change until the filtered data follows
  task automatic lat(input logic v, output int c);
    u_node.set_line(v);
    c = 0;
    do begin @(posedge mclk); c++; @(negedge mclk); end
      while (rx_data !== v && c < 50);
  endtask
  task automatic watch(input int n);
    lo = 1'b1;
    repeat (n) begin @(negedge mclk); lo &= rx_data; end
  endtask
  // cycles from a transmit start to its first bit tick
  task automatic first(input logic b, output int c);
    @(posedge mclk);
    tx_start <= 1'b1;
    tx_b2b <= b;
    @(posedge mclk);
    tx_start <= 1'b0;
    c = 0;
    do begin @(negedge mclk); c++; end while (tx_baud_tick !== 1'b1 && c < 2000);
  endtask
  // cycles from the filtered start edge to the first receive bit tick
  task automatic hunt(output int c);
    u_node.set_line(1'b0);
    while (rx_data !== 1'b0) @(negedge mclk);
    c = 0;
    do begin @(negedge mclk); c++; end while (rx_baud_tick !== 1'b1 && c < 2000);
    u_node.set_line(1'b1);
    repeat (100) @(posedge mclk);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    complete_run();
  end

  // main sequence
  initial begin
    void'($urandom(32'h24ccf162));
    mreg[1] = {4'h0, SEL_RESET};
    mreg[2] = DIV_RESET;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(1, "sel reset");
    rd(2, "div reset");
    wr(1, 8'ha7);
    rd(1, "sel upper");
    wr(2, 8'h5c);
    rd(2, "div rw");
    byteenable <= 4'h0;
    wr(2, 8'h11);
    byteenable <= 4'hf;
    rd(2, "div lane");
    bus(1'b0, 4, 8'h0);
    chk_reg("unmapped", 32'h0, q);
    // noise rejection at three base clock rates
    for (int i = 0; i < 3; i++) begin
      cfg(8, i);
      u_node.pulse(1 << i);
      watch(40 << i);
      chk_reg("noise", 32'h1, lo);
      u_node.pulse(2 << i);
      watch(40 << i);
      chk_reg("pass", 32'h0, lo);
      repeat (40 << i) @(posedge mclk);
    end
    cfg(8, 0);
    lat(1'b0, c0);
    chk_cyc("lag fall", 5, c0);
    lat(1'b1, c0);
    chk_cyc("lag rise", 5, c0);
    // divider periods, boundary and random k, external base clock last
    for (int i = 0; i < 5; i++) begin
      k = (i == 0) ? 4 : (i == 1) ? 255 : 4 + $urandom_range(0, 40);
      m = (i == 4) ? 11 : $urandom_range(0, 3);
      per = (m == 11) ? k * 2 * EH : k << m;
      cfg(k, m);
      gap(0, c0);
      chk_cyc("serial tick", per, c0);
      gap(1, c0);
      chk_cyc("tx bit tick", 2 * per, c0);
      gap(2, c0);
      chk_cyc("rx bit tick", 2 * per, c0);
    end
    // enables kept on so only the power gate can stop the counters,
    // then a prohibited select code with power on
    for (int i = 0; i < 2; i++) begin
      if (i == 0) wr(0, 8'h60);
      else cfg(4, 12 + $urandom_range(0, 3));
      // a tick launched at the write edge may still stand one cycle
      @(negedge mclk);
      c0 = 0;
      repeat (600) begin
        @(negedge mclk);
        if (rx_serial_tick !== 1'b0 || tx_baud_tick !== 1'b0) c0++;
      end
      chk_cyc((i == 0) ? "unpowered" : "prohibited", 0, c0);
    end
    cfg(6, 0);
    first(1'b0, c0);
    first(1'b1, c1);
    chk_cyc("back to back", 2, c1 - c0);
    rx_hunt <= 1'b1;
    cfg(4, 0);
    hunt(c0);
    cfg(8, 0);
    hunt(c1);
    chk_cyc("rx restart", 4, c1 - c0);
    rx_hunt <= 1'b0;
    // short then long break, status cleared between
    cfg(4, 0);
    wr(0, 8'ha1);
    u_node.pulse(80);
    repeat (40) @(posedge mclk);
    bus(1'b0, 3, 8'h0);
    chk_reg("short break", 32'h1, q & 32'h3);
    bus(1'b0, 0, 8'h0);
    chk_reg("still armed", 32'h1, q & 32'h1);
    wr(3, 8'h03);
    u_node.pulse(96);
    repeat (40) @(posedge mclk);
    bus(1'b0, 3, 8'h0);
    chk_reg("long break", 32'h2, q & 32'h3);
    bus(1'b0, 0, 8'h0);
    chk_reg("disarmed", 32'h0, q & 32'h1);
    complete_run();
  end
endmodule // uart_rx_filter_baud_generator_bench
`default_nettype wire
